// ===== design/rspc_cfg_if.sv
// Interface carrying the decoded phase configuration
`timescale 1ns/1ps
interface rspc_cfg_if;
  logic [3:0] pattern;
  logic [1:0] core_phases;
  logic [1:0] aux_phases;
  logic supported;
  modport dec (input pattern, output core_phases, aux_phases, supported);
  modport top (output pattern, input core_phases, aux_phases, supported);
endinterface

// ===== design/rspc_decode.sv
// Phase configuration decoder and validity check
`timescale 1ns/1ps
module rspc_decode
  import rspc_pkg::*;
(
  rspc_cfg_if.dec cfg,
  input wire logic all_core_variant
);
  logic [3:0] number;
  logic [13:0] accept;
  always_comb begin
    unique case (cfg.pattern[3:2])
      2'b00: cfg.core_phases = 2'd3;
      2'b01: cfg.core_phases = 2'd2;
      2'b11: cfg.core_phases = 2'd1;
      default: cfg.core_phases = 2'd0;
    endcase
    unique case (cfg.pattern[1:0])
      2'b00: cfg.aux_phases = 2'd2;
      2'b01: cfg.aux_phases = 2'd1;
      2'b11: cfg.aux_phases = 2'd0;
      default: cfg.aux_phases = 2'd3;
    endcase
    // Row number within the variant's table
    number = 4'd0;
    unique case (cfg.pattern)
      4'b0000: number = all_core_variant ? 4'd4 : 4'd1;
      4'b0001: number = all_core_variant ? 4'd5 : 4'd2;
      4'b0011: number = all_core_variant ? 4'd6 : 4'd3;
      4'b0100: number = all_core_variant ? 4'd9 : 4'd7;
      4'b0101: number = all_core_variant ? 4'd10 : 4'd8;
      4'b0111: number = 4'd11;
      4'b1101: number = all_core_variant ? 4'd13 : 4'd12;
      4'b1111: number = 4'd14;
      default: number = 4'd0;
    endcase
    accept = all_core_variant ? RSPC_ACCEPT_ALL_CORE : RSPC_ACCEPT_TWO_CORE;
    cfg.supported = (number != 4'd0) && accept[number - 4'd1];
  end
endmodule

// ===== design/rspc_pkg.sv
// Constants and types for the regulator state and phase configuration block
package rspc_pkg;
  localparam logic [7:0] RSPC_CODE_LOW = 8'hD7;
  localparam logic [7:0] RSPC_CODE_ZERO = 8'h00;
  localparam int RSPC_UV_AT_LOW = 1320000;
  localparam int RSPC_UV_STEP = 5000;
  localparam logic [3:0] RSPC_AUX_ADDR = 4'h1;
  localparam int RSPC_CAL_NS = 1000;
  localparam int RSPC_CLK_NS = 50;
  localparam int RSPC_CAL_CYC = (RSPC_CAL_NS + RSPC_CLK_NS - 1) / RSPC_CLK_NS;
  localparam int RSPC_SS_NS = 2000;
  localparam int RSPC_SS_CYC = (RSPC_SS_NS + RSPC_CLK_NS - 1) / RSPC_CLK_NS;
  localparam logic [13:0] RSPC_ACCEPT_TWO_CORE = 14'h2CC7;
  localparam logic [13:0] RSPC_ACCEPT_ALL_CORE = 14'h3738;
  localparam logic [15:0] RSPC_PATTERN_TO_CFG = 16'h0000;
  typedef enum logic [2:0] {
    RSPC_DISABLED = 3'b000,
    RSPC_CAL = 3'b001,
    RSPC_SOFT = 3'b011,
    RSPC_NORMAL = 3'b010,
    RSPC_ZERO = 3'b110,
    RSPC_DRV_FAULT = 3'b101,
    RSPC_HALT = 3'b100
  } rspc_state_t;
endpackage

// ===== design/rspc_top.sv
// Regulator state sequencer with start-up phase configuration capture
`timescale 1ns/1ps
module rspc_top
  import rspc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic supply_lockout,
  input wire logic enable_in,
  input wire logic all_core_variant,
  input wire logic [3:0] phase_sense_pins,
  input wire logic driver_enable_line_in,
  input wire logic soft_start_done,
  input wire logic [7:0] voltage_code,
  input wire logic voltage_code_valid,
  input wire logic [3:0] bus_address,
  input wire logic bus_command,
  input wire logic zero_code_power_good,
  input wire logic [3:0] config_write_data,
  input wire logic config_write,
  output logic power_good_out,
  output logic comp_enable,
  output logic overvoltage_protect,
  output logic undervoltage_protect,
  output logic protect_latching,
  output logic driver_enable_line_out,
  output logic driver_enable_line_oe,
  output logic driver_pullup_on,
  output logic driver_pulldown_on,
  output logic pwm_low,
  output logic low_side_gate_outs_high,
  output logic switching_allowed,
  output logic [3:0] user_config_register,
  output logic [1:0] core_phases,
  output logic [1:0] aux_phases,
  output logic config_unsupported,
  output logic bus_accept,
  output logic [20:0] target_microvolts,
  output rspc_state_t state_out
);
  typedef struct packed {
    logic [1:0] lock_sync;
    logic [1:0] en_sync;
    logic [1:0] drv_sync;
    logic [3:0] s1;
    logic [3:0] s2;
    rspc_state_t state;
    logic [7:0] count;
    logic [3:0] user_cfg;
    logic captured;
    logic [7:0] code;
    logic [20:0] uv;
    logic bus_ack;
  } rspc_st_t;
  rspc_st_t r;
  rspc_st_t next_r;
  logic lock;
  logic en;
  logic drv;
  rspc_cfg_if cfg ();
  assign cfg.pattern = r.user_cfg;
  rspc_decode u_dec (
    .cfg(cfg),
    .all_core_variant(all_core_variant)
  );
  assign lock = r.lock_sync[1];
  assign en = r.en_sync[1];
  assign drv = r.drv_sync[1];
  always_comb begin
    next_r = r;
    // Lockout, enable, driver line and phase sense pins pass two flops before use
    next_r.lock_sync = {r.lock_sync[0], supply_lockout};
    next_r.en_sync = {r.en_sync[0], enable_in};
    next_r.drv_sync = {r.drv_sync[0], driver_enable_line_in};
    next_r.s1 = phase_sense_pins;
    next_r.s2 = r.s1;
    next_r.bus_ack = 1'b0;
    if (r.count != 8'd0) begin
      next_r.count = r.count - 8'd1;
    end
    if (lock) begin
      next_r.state = RSPC_DISABLED;
      next_r.captured = 1'b0;
      next_r.count = 8'd0;
    end else begin
      unique case (r.state)
        RSPC_DISABLED: begin
          if (en) begin
            next_r.state = RSPC_CAL;
            next_r.count = 8'(RSPC_CAL_CYC);
          end
        end
        RSPC_CAL: begin
          if (!r.captured) begin
            next_r.user_cfg = r.s2;
            next_r.captured = 1'b1;
          end
          if (!en) begin
            next_r.state = RSPC_DISABLED;
          end else if (r.count == 8'd0 && r.captured) begin
            if (!cfg.supported) begin
              next_r.state = RSPC_HALT;
            end else if (!drv) begin
              next_r.state = RSPC_DRV_FAULT;
            end else begin
              next_r.state = RSPC_SOFT;
              next_r.count = 8'(RSPC_SS_CYC);
            end
          end
        end
        RSPC_DRV_FAULT: begin
          if (!en) begin
            next_r.state = RSPC_DISABLED;
          end else if (drv) begin
            next_r.state = RSPC_SOFT;
            next_r.count = 8'(RSPC_SS_CYC);
          end
        end
        RSPC_SOFT: begin
          if (!en) begin
            next_r.state = RSPC_DISABLED;
          end else if (soft_start_done && r.count == 8'd0) begin
            next_r.state = RSPC_NORMAL;
          end
        end
        RSPC_NORMAL: begin
          if (!en) begin
            next_r.state = RSPC_DISABLED;
          end else if (voltage_code_valid && voltage_code == RSPC_CODE_ZERO) begin
            next_r.state = RSPC_ZERO;
          end
        end
        RSPC_ZERO: begin
          if (!en) begin
            next_r.state = RSPC_DISABLED;
          end else if (voltage_code_valid && voltage_code != RSPC_CODE_ZERO) begin
            next_r.state = RSPC_NORMAL;
          end
        end
        RSPC_HALT: begin
          if (!en) begin
            next_r.state = RSPC_DISABLED;
          end
        end
        default: next_r.state = RSPC_DISABLED;
      endcase
    end
    // Writes ignored once captured
    // Pin capture wins over a write in its cycle
    if (config_write && !r.captured && !lock && r.state != RSPC_CAL) begin
      next_r.user_cfg = config_write_data;
    end
    if (voltage_code_valid) begin
      next_r.code = voltage_code;
      if (voltage_code >= RSPC_CODE_LOW) begin
        next_r.uv = 21'(RSPC_UV_AT_LOW + RSPC_UV_STEP * int'(voltage_code - RSPC_CODE_LOW));
      end else begin
        next_r.uv = 21'd0;
      end
    end
    if (bus_command && r.captured) begin
      next_r.bus_ack = !(bus_address == RSPC_AUX_ADDR && cfg.aux_phases == 2'd0);
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  always_comb begin
    power_good_out = 1'b0;
    comp_enable = 1'b0;
    overvoltage_protect = 1'b0;
    protect_latching = 1'b0;
    driver_enable_line_out = 1'b0;
    driver_enable_line_oe = 1'b0;
    driver_pullup_on = 1'b0;
    pwm_low = 1'b1;
    low_side_gate_outs_high = 1'b0;
    unique case (r.state)
      RSPC_DRV_FAULT: driver_pullup_on = 1'b1;
      RSPC_SOFT: begin
        comp_enable = 1'b1;
        overvoltage_protect = 1'b1;
        driver_enable_line_out = 1'b1;
        driver_enable_line_oe = 1'b1;
        pwm_low = 1'b0;
      end
      RSPC_NORMAL: begin
        power_good_out = 1'b1;
        comp_enable = 1'b1;
        overvoltage_protect = 1'b1;
        protect_latching = 1'b1;
        driver_enable_line_out = 1'b1;
        driver_enable_line_oe = 1'b1;
        pwm_low = 1'b0;
      end
      RSPC_ZERO: begin
        power_good_out = zero_code_power_good;
        driver_enable_line_out = 1'b1;
        driver_enable_line_oe = 1'b1;
        low_side_gate_outs_high = 1'b1;
      end
      default: power_good_out = 1'b0;
    endcase
    undervoltage_protect = overvoltage_protect;
    driver_pulldown_on = lock;
    switching_allowed = r.state == RSPC_SOFT || r.state == RSPC_NORMAL;
    user_config_register = r.user_cfg;
    core_phases = cfg.core_phases;
    aux_phases = cfg.aux_phases;
    config_unsupported = r.captured && !cfg.supported;
    bus_accept = r.bus_ack;
    target_microvolts = r.uv;
    state_out = r.state;
  end

  property p_unsup;
    @(posedge clock) disable iff (rst) config_unsupported |-> !switching_allowed;
  endproperty
  a_unsup: assert property (p_unsup) else $error("switching with unsupported config");
  property p_ro;
    @(posedge clock) disable iff (rst) r.captured && !lock |=> $stable(user_config_register);
  endproperty
  a_ro: assert property (p_ro) else $error("config register changed");
  property p_pg;
    @(posedge clock) disable iff (rst) state_out == RSPC_SOFT |-> !power_good_out && driver_enable_line_out;
  endproperty
  a_pg: assert property (p_pg) else $error("soft start outputs wrong");
  property p_aux;
    @(posedge clock) disable iff (rst)
      bus_command && bus_address == RSPC_AUX_ADDR && aux_phases == 2'd0 |=> !bus_accept;
  endproperty
  a_aux: assert property (p_aux) else $error("disabled aux answered");
  property p_fault;
    @(posedge clock) disable iff (rst) state_out == RSPC_DRV_FAULT |-> driver_pullup_on && !comp_enable;
  endproperty
  a_fault: assert property (p_fault) else $error("driver fault outputs wrong");
  property p_map;
    @(posedge clock) disable iff (rst)
      voltage_code_valid && voltage_code == 8'hFF |=> target_microvolts == 21'd1520000;
  endproperty
  a_map: assert property (p_map) else $error("top code voltage wrong");
  property p_lock;
    @(posedge clock) disable iff (rst) lock |=> state_out == RSPC_DISABLED;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout did not reset");
  property p_zero;
    @(posedge clock) disable iff (rst)
      state_out == RSPC_ZERO |-> low_side_gate_outs_high && pwm_low && !comp_enable;
  endproperty
  a_zero: assert property (p_zero) else $error("zero code outputs wrong");
  property p_quiet;
    @(posedge clock) disable iff (rst) (state_out == RSPC_DISABLED || state_out == RSPC_CAL)
      |-> !power_good_out && !comp_enable && !overvoltage_protect && !driver_enable_line_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs active before soft start");
  sequence s_cal_first;
    state_out == RSPC_CAL && !r.captured && !lock;
  endsequence
  property p_capture;
    @(posedge clock) disable iff (rst) s_cal_first |=> r.captured && user_config_register == $past(r.s2);
  endproperty
  a_capture: assert property (p_capture) else $error("pin pattern not captured");
endmodule

// ===== tb/rspc_drv_model.sv
// External driver model sitting on the shared driver enable line
`timescale 1ns/1ps
module rspc_drv_model (
  input wire logic hold_low,
  input wire logic drv_out,
  input wire logic drv_oe,
  input wire logic pullup_on,
  input wire logic pulldown_on,
  output logic line
);
  // line resolution
  // The driver clamps the line low until ready; once released, a pull-up lifts it
  assign line = hold_low ? 1'b0 : drv_oe ? drv_out : pullup_on | !pulldown_on;
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the regulator sequencer
`timescale 1ns/1ps
module testbench;
  import rspc_pkg::*;
  logic clock, rst, lo, en, vs, line, ss, cv, cmd, zpg, cw, hl;
  logic pg, comp, ov_prot, uv_prot, lat, dout, doe, pu, pd, pwl, lsg, sw, uns, acc;
  logic [3:0] pins, addr, cwd, ucfg;
  logic [7:0] code;
  logic [1:0] cn, an;
  logic [20:0] tgt;
  rspc_state_t st;
  int fail_count, n_tests;
  rspc_top i_rspc_top (.clock(clock), .rst(rst), .supply_lockout(lo), .enable_in(en),
    .all_core_variant(vs), .phase_sense_pins(pins), .driver_enable_line_in(line),
    .soft_start_done(ss), .voltage_code(code), .voltage_code_valid(cv), .bus_address(addr),
    .bus_command(cmd), .zero_code_power_good(zpg), .config_write_data(cwd), .config_write(cw),
    .power_good_out(pg), .comp_enable(comp), .overvoltage_protect(ov_prot), .undervoltage_protect(uv_prot),
    .protect_latching(lat), .driver_enable_line_out(dout), .driver_enable_line_oe(doe),
    .driver_pullup_on(pu), .driver_pulldown_on(pd), .pwm_low(pwl), .low_side_gate_outs_high(lsg),
    .switching_allowed(sw), .user_config_register(ucfg), .core_phases(cn), .aux_phases(an),
    .config_unsupported(uns), .bus_accept(acc), .target_microvolts(tgt), .state_out(st));
  rspc_drv_model i_rspc_drv_model (.hold_low(hl), .drv_out(dout), .drv_oe(doe),
    .pullup_on(pu), .pulldown_on(pd), .line(line));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Bounded wait; a hang ends the run
  task automatic wait_st(input rspc_state_t s);
    int i;
    for (i = 0; i < 200 && st !== s; i++) @(negedge clock);
    if (st !== s) begin
      fail_count++;
      $display("[FAIL] state expected %0d seen %0d", s, st);
      print_verdict();
    end
  endtask
  task automatic power_up(input logic [3:0] p, input logic v);
    lo = 1;
    en = 0;
    pins = p;
    vs = v;
    repeat (4) @(negedge clock);
    chk("pulldown", pd, 1'h1); // passive pull down
    chk("lockout_state", st, RSPC_DISABLED); // held in reset
    lo = 0;
    repeat (4) @(negedge clock);
    en = 1;
    wait_st(RSPC_CAL);
  endtask
  task automatic t_config(input logic [3:0] p, input logic v);
    logic [1:0] c, a;
    logic sup;
    c = p[3:2];
    a = p[1:0];
    sup = c != 2'h2 && a != 2'h2 && !(c == 2'h3 && a == 2'h0);
    power_up(p, v);
    chk("cal_outs", {pg, comp, ov_prot, uv_prot, dout}, 5'h00); // calibration outputs
    repeat (2) @(negedge clock);
    pins = ~p;
    cwd = ~p;
    cw = 1;
    @(negedge clock);
    cw = 0;
    wait_st(sup ? RSPC_SOFT : RSPC_HALT); // halt on bad pattern
    chk("user_cfg", ucfg, p); // captured once
    chk("core", cn, c == 0 ? 2'h3 : c == 1 ? 2'h2 : c == 3 ? 2'h1 : 2'h0); // core count
    chk("aux", an, a == 0 ? 2'h2 : a == 1 ? 2'h1 : a == 3 ? 2'h0 : 2'h3); // aux count
    chk("unsup", uns, !sup); // accepted set
    chk("switching", {sw, dout & doe}, sup ? 2'h3 : 2'h0); // switching only if supported
  endtask
  task automatic t_fault();
    hl = 1;
    ss = 0;
    power_up(4'h0, 1'h0);
    wait_st(RSPC_DRV_FAULT);
    chk("fault", {pg, comp, ov_prot, uv_prot, pu}, 5'h01); // pull up, outputs low
    hl = 0;
    wait_st(RSPC_SOFT);
    chk("soft", {pg, comp, ov_prot, lat, dout, doe}, 6'h1B); // soft start
    ss = 1;
    wait_st(RSPC_NORMAL);
    chk("normal", {pg, ov_prot, uv_prot, lat, dout}, 5'h1F); // normal latching
    $display("test fault and start-up done");
  endtask
  task automatic send_code(input logic [7:0] c);
    code = c;
    cv = 1;
    @(negedge clock);
    cv = 0;
    @(negedge clock);
  endtask
  task automatic t_codes();
    logic [7:0] tab [4] = '{8'hD7, 8'hEB, 8'hF0, 8'hFF};
    for (int k = 0; k < 4; k++) begin
      send_code(tab[k]);
      chk("uv", tgt, RSPC_UV_AT_LOW + (tab[k] - 8'hD7) * RSPC_UV_STEP); // code scale
    end
    zpg = 1;
    send_code(8'h00);
    wait_st(RSPC_ZERO);
    chk("zero", {pg, comp, ov_prot, uv_prot, dout, doe, pwl, lsg}, 8'h8F); // parked outputs
    zpg = 0;
    repeat (2) @(negedge clock);
    chk("zero_pg", pg, 1'h0); // follows setting
    send_code(8'hE0);
    wait_st(RSPC_NORMAL); // leaves on valid code
    $display("test codes done");
  endtask
  task automatic bus_try(input logic [3:0] a, input logic exp);
    addr = a;
    cmd = 1;
    @(negedge clock);
    cmd = 0;
    chk("accept", acc, exp); // aux address
    @(negedge clock);
  endtask
  task automatic t_bus();
    power_up(4'h3, 1'h1);
    wait_st(RSPC_NORMAL);
    bus_try(4'h1, 1'h0);
    bus_try(4'h0, 1'h1);
    power_up(4'h1, 1'h1);
    wait_st(RSPC_NORMAL);
    bus_try(4'h1, 1'h1);
    $display("test bus done");
  endtask
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  initial begin
    {rst, lo} = 2'h3;
    {en, vs, ss, cv, cmd, zpg, cw, hl} = 8'h00;
    {pins, addr, cwd, code} = 20'h00000;
    fail_count = 0;
    n_tests = 0;
    repeat (12) @(negedge clock);
    rst = 0;
    lo = 0;
    repeat (4) @(negedge clock);
    chk("disabled", {pg, comp, ov_prot, uv_prot, dout, st}, 8'h00); // disabled outputs
    for (int p = 0; p < 32; p++) t_config(p[3:0], p[4]);
    $display("test configurations done");
    t_fault();
    t_codes();
    t_bus();
    print_verdict();
  end
endmodule
